/* rtl/sim_presence_pkg.sv */
package sim_presence_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETTLE_TIME_MS = 2000;
  localparam int unsigned SETTLE_CYCLES_DEF = SETTLE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_W = 28;
  localparam int unsigned CCLK_DIV_DEF = 8;
  localparam int unsigned ETU_CCLK = 372;
  localparam int unsigned RST_HOLD_CCLK = 400;
  localparam int unsigned GUARD_ETU = 2;
  localparam int unsigned LCNT_W = 16;

  // ****************************************************************
  // Character framing
  // ****************************************************************
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] GUARD_LAST = 4'(GUARD_ETU - 1);

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic IO_IDLE = 1'b1;
  localparam logic RST_ACTIVE = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    LK_OFF      = 3'h0,
    LK_RST_HOLD = 3'h1,
    LK_READY    = 3'h2,
    LK_TX       = 3'h3,
    LK_RX       = 3'h4,
    LK_GUARD    = 3'h5
  } link_state_t;

  typedef struct packed {
    logic valid;
    logic [DATA_BITS-1:0] data;
  } tx_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_BITS-1:0] data;
    logic parity_err;
  } rx_char_t;

  typedef struct packed {
    logic present;
    logic inserted;
    logic removed;
    logic timing;
    logic [SETTLE_W-1:0] settle;
    logic supply;
    logic busy;
    logic tx_ready;
    logic tx_tgl;
    logic [DATA_BITS-1:0] tx_data;
    logic done_seen;
    logic rx_seen;
    logic ready;
    rx_char_t rx;
  } sys_state_t;

  typedef struct packed {
    link_state_t state;
    logic [LCNT_W-1:0] cclk_cnt;
    logic cclk;
    logic [LCNT_W-1:0] etu_cnt;
    logic [3:0] bit_cnt;
    logic [9:0] shift;
    logic rst_out;
    logic io_out;
    logic io_oe;
    logic req_seen;
    logic done_tgl;
    logic rx_tgl;
    logic [DATA_BITS-1:0] rx_data;
    logic rx_perr;
    logic ready;
  } link_state_reg_t;

endpackage : sim_presence_pkg

/* rtl/sync_2ff.sv */
`timescale 1ns/1ps

// Two-stage synchroniser; the first stage feeds only the second
module sync_2ff #(
  parameter int unsigned W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // Stages
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sync_2ff

/* rtl/sim_presence_power_seq.sv */
// What this block does
// - A low-to-high presence transition is taken as card insertion.
// - A high-to-low presence transition is taken as card removal.
// - Presence edges raise one-cycle events, and the block acts on the presence level.
// - Card supply turns on only after presence has stayed high two seconds.
// - Card reset, card clock and card data line follow the smart card protocol.
`timescale 1ns/1ps

module sim_presence_power_seq
  import sim_presence_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = sim_presence_pkg::SETTLE_CYCLES_DEF,
  parameter int unsigned CCLK_DIV = sim_presence_pkg::CCLK_DIV_DEF
) (
  // System clock domain
  input wire logic clk,
  input wire logic rst,
  // Card link clock domain
  input wire logic link_clk,
  input wire logic link_rst,
  // Socket detect switch
  input wire logic card_presence_in,
  // Presence status and events
  output logic card_present,
  output logic card_inserted,
  output logic card_removed,
  // Card supply
  output logic card_supply_enable,
  // Character transmit request
  input wire sim_presence_pkg::tx_req_t tx_req,
  output logic tx_ready,
  // Character receive and link status
  output sim_presence_pkg::rx_char_t rx_char,
  output logic card_ready,
  // Card pins
  output logic card_reset_out,
  output logic card_clock_out,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe
);

  // ****************************************************************
  // Derived counts
  // ****************************************************************
  localparam int unsigned HALF_DIV = CCLK_DIV / 2;
  localparam int unsigned ETU_LINK = ETU_CCLK * CCLK_DIV;
  localparam int unsigned RST_HOLD_LINK = RST_HOLD_CCLK * CCLK_DIV;
  localparam logic [LCNT_W-1:0] HALF_LAST = LCNT_W'(HALF_DIV - 1);
  localparam logic [LCNT_W-1:0] ETU_LAST = LCNT_W'(ETU_LINK - 1);
  localparam logic [LCNT_W-1:0] ETU_MID = LCNT_W'(ETU_LINK / 2 - 1);
  localparam logic [LCNT_W-1:0] RST_LAST = LCNT_W'(RST_HOLD_LINK - 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (CCLK_DIV < 2 || (CCLK_DIV % 2) != 0) begin : g_bad_div
    $error("CCLK_DIV must be even and at least 2");
  end
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > (1 << SETTLE_W)) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range for the settle counter");
  end
  if (RST_HOLD_LINK >= (1 << LCNT_W) || ETU_LINK >= (1 << LCNT_W)) begin : g_bad_cnt
    $error("Link counts exceed the link counter width");
  end

  sys_state_t s_q;
  sys_state_t s_d;
  link_state_reg_t l_q;
  link_state_reg_t l_d;

  logic pres_s;
  logic [2:0] to_sys_s;
  logic [2:0] to_link_s;
  logic ready_s;
  logic done_s;
  logic rxt_s;
  logic power_s;
  logic req_s;
  logic io_s;

  // ****************************************************************
  // Crossings into the system domain
  // ****************************************************************
  sync_2ff #(.W(1)) u_sync_pres (
    .clk(clk),
    .rst(rst),
    .d(card_presence_in),
    .q(pres_s)
  );

  sync_2ff #(.W(3)) u_sync_sys (
    .clk(clk),
    .rst(rst),
    .d({l_q.ready, l_q.done_tgl, l_q.rx_tgl}),
    .q(to_sys_s)
  );

  // ****************************************************************
  // Crossings into the link domain
  // ****************************************************************
  sync_2ff #(.W(3)) u_sync_link (
    .clk(link_clk),
    .rst(link_rst),
    .d({s_q.supply, s_q.tx_tgl, card_io_in}),
    .q(to_link_s)
  );

  assign ready_s = to_sys_s[2];
  assign done_s = to_sys_s[1];
  assign rxt_s = to_sys_s[0];
  assign power_s = to_link_s[2];
  assign req_s = to_link_s[1];
  assign io_s = to_link_s[0];

  // ****************************************************************
  // System domain: presence, settle timer, supply, handshakes
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // Presence level and its edges as one-cycle events
    s_d.present = pres_s;
    s_d.inserted = pres_s & ~s_q.present;
    s_d.removed = ~pres_s & s_q.present;
    // Settle timer before the supply may rise
    if (!pres_s) begin
      s_d.timing = 1'b0;
      s_d.settle = '0;
      s_d.supply = 1'b0;
    end else if (!s_q.present) begin
      s_d.timing = 1'b1;
      s_d.settle = '0;
    end else if (s_q.timing) begin
      if (s_q.settle == SETTLE_LAST) begin
        s_d.timing = 1'b0;
        s_d.supply = 1'b1;
      end else begin
        s_d.settle = s_q.settle + 1'b1;
      end
    end
    // Transmit handshake toward the link
    s_d.ready = ready_s;
    if (!ready_s) begin
      s_d.busy = 1'b0;
      s_d.done_seen = done_s;
    end else if (done_s != s_q.done_seen) begin
      s_d.done_seen = done_s;
      s_d.busy = 1'b0;
    end else if (tx_req.valid && s_q.tx_ready) begin
      s_d.busy = 1'b1;
      s_d.tx_data = tx_req.data;
      s_d.tx_tgl = ~s_q.tx_tgl;
    end
    s_d.tx_ready = ~s_d.busy & ready_s & ~(tx_req.valid & s_q.tx_ready);
    // Received character from the link, held stable by the link
    s_d.rx.valid = 1'b0;
    if (rxt_s != s_q.rx_seen) begin
      s_d.rx_seen = rxt_s;
      s_d.rx.valid = 1'b1;
      s_d.rx.data = l_q.rx_data;
      s_d.rx.parity_err = l_q.rx_perr;
    end
  end

  // System domain register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Link domain: activation, card clock, character transfer
  // ****************************************************************
  always_comb begin
    l_d = l_q;
    // Card clock runs whenever the card is powered
    if (l_q.state == LK_OFF) begin
      l_d.cclk_cnt = '0;
      l_d.cclk = 1'b0;
    end else if (l_q.cclk_cnt == HALF_LAST) begin
      l_d.cclk_cnt = '0;
      l_d.cclk = ~l_q.cclk;
    end else begin
      l_d.cclk_cnt = l_q.cclk_cnt + 1'b1;
    end
    if (!power_s) begin
      // Deactivation: reset low, clock stopped, line released
      l_d.state = LK_OFF;
      l_d.rst_out = RST_ACTIVE;
      l_d.io_oe = 1'b0;
      l_d.io_out = IO_IDLE;
      l_d.ready = 1'b0;
      l_d.etu_cnt = '0;
      l_d.bit_cnt = '0;
      l_d.req_seen = req_s;
    end else begin
      case (l_q.state)
        LK_OFF: begin
          l_d.state = LK_RST_HOLD;
          l_d.etu_cnt = '0;
          l_d.req_seen = req_s;
        end
        LK_RST_HOLD: begin
          // Reset held low for the cold reset time, then released
          if (l_q.etu_cnt == RST_LAST) begin
            l_d.etu_cnt = '0;
            l_d.rst_out = ~RST_ACTIVE;
            l_d.ready = 1'b1;
            l_d.state = LK_READY;
          end else begin
            l_d.etu_cnt = l_q.etu_cnt + 1'b1;
          end
        end
        LK_READY: begin
          l_d.etu_cnt = '0;
          l_d.bit_cnt = '0;
          if (!io_s) begin
            l_d.state = LK_RX;
          end else if (req_s != l_q.req_seen) begin
            // Start bit, data LSB first, even parity
            l_d.req_seen = req_s;
            l_d.shift = {^s_q.tx_data, s_q.tx_data, 1'b0};
            l_d.io_oe = 1'b1;
            l_d.io_out = 1'b0;
            l_d.state = LK_TX;
          end
        end
        LK_TX: begin
          if (l_q.etu_cnt == ETU_LAST) begin
            l_d.etu_cnt = '0;
            if (l_q.bit_cnt == LAST_BIT) begin
              l_d.io_oe = 1'b0;
              l_d.io_out = IO_IDLE;
              l_d.bit_cnt = '0;
              l_d.done_tgl = ~l_q.done_tgl;
              l_d.state = LK_GUARD;
            end else begin
              l_d.bit_cnt = l_q.bit_cnt + 1'b1;
              l_d.shift = {1'b1, l_q.shift[9:1]};
              l_d.io_out = l_q.shift[1];
            end
          end else begin
            l_d.etu_cnt = l_q.etu_cnt + 1'b1;
          end
        end
        LK_RX: begin
          // First sample at mid start bit, then one per elementary time
          if ((l_q.bit_cnt == 4'h0 && l_q.etu_cnt == ETU_MID) ||
              (l_q.bit_cnt != 4'h0 && l_q.etu_cnt == ETU_LAST)) begin
            l_d.etu_cnt = '0;
            if (l_q.bit_cnt == 4'h0) begin
              if (io_s) begin
                l_d.state = LK_READY; // Glitch, not a start bit
              end else begin
                l_d.bit_cnt = 4'h1;
              end
            end else begin
              l_d.shift = {io_s, l_q.shift[9:1]};
              if (l_q.bit_cnt == LAST_BIT) begin
                l_d.rx_data = l_d.shift[8:1];
                l_d.rx_perr = ^l_d.shift[9:1];
                l_d.rx_tgl = ~l_q.rx_tgl;
                l_d.bit_cnt = '0;
                l_d.state = LK_GUARD;
              end else begin
                l_d.bit_cnt = l_q.bit_cnt + 1'b1;
              end
            end
          end else begin
            l_d.etu_cnt = l_q.etu_cnt + 1'b1;
          end
        end
        LK_GUARD: begin
          // Guard time between characters
          if (l_q.etu_cnt == ETU_LAST) begin
            l_d.etu_cnt = '0;
            if (l_q.bit_cnt == GUARD_LAST) begin
              l_d.bit_cnt = '0;
              l_d.state = LK_READY;
            end else begin
              l_d.bit_cnt = l_q.bit_cnt + 1'b1;
            end
          end else begin
            l_d.etu_cnt = l_q.etu_cnt + 1'b1;
          end
        end
        default: begin
          l_d.state = LK_OFF;
        end
      endcase
    end
  end

  // Link domain register
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      l_q <= '0;
      l_q.state <= LK_OFF;
      l_q.io_out <= IO_IDLE;
      l_q.rst_out <= RST_ACTIVE;
    end else begin
      l_q <= l_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign card_present = s_q.present;
  assign card_inserted = s_q.inserted;
  assign card_removed = s_q.removed;
  assign card_supply_enable = s_q.supply;
  assign tx_ready = s_q.tx_ready;
  assign rx_char = s_q.rx;
  assign card_ready = s_q.ready;
  assign card_reset_out = l_q.rst_out;
  assign card_clock_out = l_q.cclk;
  assign card_io_out = l_q.io_out;
  assign card_io_oe = l_q.io_oe;

endmodule : sim_presence_power_seq

/* dv/sim_presence_power_seq_sva.sv */
`timescale 1ns/1ps

module sim_presence_power_seq_sva #(
  parameter int unsigned SETTLE_CYCLES = 50,
  parameter int unsigned CCLK_DIV = 8
) (
  // Clocks and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  // Presence and supply
  input wire logic card_presence_in,
  input wire logic card_present,
  input wire logic card_inserted,
  input wire logic card_removed,
  input wire logic card_supply_enable,
  // Card pins
  input wire logic card_reset_out,
  input wire logic card_io_out,
  input wire logic card_io_oe
);
  // ****************************************************************
  // Presence events
  // ****************************************************************
  sequence s_pin_rise;
    $rose(card_presence_in) ##1 card_presence_in;
  endsequence

  property p_insert_edge;
    @(posedge clk) disable iff (rst) card_inserted |-> $rose(card_present);
  endproperty
  a_insert_edge: assert property (p_insert_edge) else $error("insert pulse without presence rise");

  property p_remove_edge;
    @(posedge clk) disable iff (rst) card_removed |-> $fell(card_present);
  endproperty
  a_remove_edge: assert property (p_remove_edge) else $error("remove pulse without presence fall");

  property p_pin_event;
    @(posedge clk) disable iff (rst) s_pin_rise |-> ##[0:3] card_inserted;
  endproperty
  a_pin_event: assert property (p_pin_event) else $error("pin rise raised no insert event");

  // ****************************************************************
  // Supply sequencing and start of character
  // ****************************************************************
  property p_settle;
    @(posedge clk) disable iff (rst) $rose(card_supply_enable) |-> $past(card_inserted, SETTLE_CYCLES);
  endproperty
  a_settle: assert property (p_settle) else $error("supply rose off the settle count");

  property p_cut;
    @(posedge clk) disable iff (rst) $fell(card_present) |-> card_removed && !card_supply_enable;
  endproperty
  a_cut: assert property (p_cut) else $error("supply kept after removal");

  property p_start_bit;
    @(posedge link_clk) disable iff (link_rst) $rose(card_io_oe) |-> !card_io_out && card_reset_out;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("bad start of character");
endmodule : sim_presence_power_seq_sva

bind sim_presence_power_seq sim_presence_power_seq_sva #(.SETTLE_CYCLES(SETTLE_CYCLES), .CCLK_DIV(CCLK_DIV)) sva_inst (
  .clk, .rst, .link_clk, .link_rst, .card_presence_in, .card_present, .card_inserted, .card_removed,
  .card_supply_enable, .card_reset_out, .card_io_out, .card_io_oe);

/* dv/sim_socket_model.sv */
`timescale 1ns/1ps

module sim_socket_model (
  // Bench control
  input wire logic card_seated,
  // Block pins
  input wire logic card_clock_out,
  input wire logic card_io_out,
  input wire logic card_io_oe,
  output logic card_presence_in,
  output logic card_io_in
);
  logic card_drv = 1'b1;
  logic [8:0] rx_word = 9'h000;

  // Switch grounds the detect line while no card is seated
  assign card_presence_in = card_seated;
  // Pulled-up line, low when either side pulls it down
  assign card_io_in = (card_io_oe ? card_io_out : 1'b1) & card_drv;

  // Card sends a character, parity optionally flipped
  task automatic send(input logic [7:0] b, input logic par_flip);
    logic [9:0] f;
    f = {^b ^ par_flip, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      card_drv = f[i];
      repeat (372) @(posedge card_clock_out);
    end
    card_drv = 1'b1;
  endtask : send

  // Card samples the block's character at mid-bit
  always @(posedge card_io_oe) begin
    repeat (186) @(posedge card_clock_out);
    for (int i = 0; i < 9; i++) begin
      repeat (372) @(posedge card_clock_out);
      rx_word[i] = card_io_in;
    end
  end
endmodule : sim_socket_model

/* dv/tb_sim_presence_power_seq.sv */
`timescale 1ns/1ps

module tb_sim_presence_power_seq;
  import sim_presence_pkg::*;
  localparam int unsigned SETTLE = 50;
  localparam int unsigned DIV = 2;
  // One elementary time in system cycles; the link period is three system periods
  localparam int unsigned ETU_CLK = ETU_CCLK * DIV * 3;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic seated = 1'b0;
  tx_req_t tx_req = '0;
  rx_char_t rx_char;
  logic card_presence_in, card_present, card_inserted, card_removed, card_supply_enable, tx_ready, card_ready;
  logic card_reset_out, card_clock_out, card_io_in, card_io_out, card_io_oe;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clocks: system 10 ns, link 30 ns with a phase offset
  always #5 clk = ~clk;
  initial begin
    #2;
    forever #15 link_clk = ~link_clk;
  end

  sim_presence_power_seq #(.SETTLE_CYCLES(SETTLE), .CCLK_DIV(DIV)) sim_presence_power_seq_inst (
    .clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(rst), .card_presence_in(card_presence_in),
    .card_present(card_present), .card_inserted(card_inserted), .card_removed(card_removed),
    .card_supply_enable(card_supply_enable), .tx_req(tx_req), .tx_ready(tx_ready), .rx_char(rx_char),
    .card_ready(card_ready), .card_reset_out(card_reset_out), .card_clock_out(card_clock_out),
    .card_io_in(card_io_in), .card_io_out(card_io_out), .card_io_oe(card_io_oe));

  sim_socket_model sim_socket_model_inst (
    .card_seated(seated), .card_clock_out(card_clock_out), .card_io_out(card_io_out),
    .card_io_oe(card_io_oe), .card_presence_in(card_presence_in), .card_io_in(card_io_in));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Wait for a flag with a bounded count, returns cycles waited
  task automatic wait_for(ref logic flag, input int limit, output int n);
    n = 0;
    while (flag !== 1'b1 && n < limit) begin
      step(1);
      n++;
    end
    // A wait that runs out counts as a mismatch
    if (flag !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, flag, 1'b1);
    end
  endtask : wait_for

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    check({card_present, card_supply_enable, tx_ready, card_ready, card_reset_out, card_io_oe}, 16'h0000);
    check(16'(rx_char), 16'h0000);
  endtask : t_reset_values

  task automatic t_cancel_settle();
    int n;
    seated = 1'b1;
    wait_for(card_inserted, 10, n);
    check({card_inserted, card_present}, 16'h0003);
    step(SETTLE - 5);
    seated = 1'b0;
    wait_for(card_removed, 10, n);
    check({card_removed, card_supply_enable}, 16'h0002);
    step(SETTLE + 10);
    check({15'h0, card_supply_enable}, 16'h0000);
  endtask : t_cancel_settle

  task automatic t_settle_time();
    int n;
    seated = 1'b1;
    wait_for(card_inserted, 10, n);
    wait_for(card_supply_enable, SETTLE + 10, n);
    check(16'(n), 16'(SETTLE));
  endtask : t_settle_time

  task automatic t_link_tx();
    int n;
    wait_for(card_ready, 5000, n);
    wait_for(tx_ready, 100, n);
    check({card_reset_out, card_ready, tx_ready}, 16'h0007);
    tx_req = '{valid: 1'b1, data: 8'hA5};
    step(1);
    tx_req = '0;
    step(3);
    wait_for(tx_ready, 40000, n);
    check(16'(sim_socket_model_inst.rx_word), 16'h00A5);
  endtask : t_link_tx

  task automatic t_rx_parity();
    int n;
    // Card keeps the guard time after the block's last character
    step(GUARD_ETU * ETU_CLK + 100);
    fork
      sim_socket_model_inst.send(8'h3B, 1'b1);
    join_none
    n = 0;
    while (rx_char.valid !== 1'b1 && n < 40000) begin
      step(1);
      n++;
    end
    check(16'(rx_char), 16'h0277);
    step(1);
    check(16'(rx_char), 16'h0077);
  endtask : t_rx_parity

  task automatic t_remove_powered();
    int n;
    seated = 1'b0;
    wait_for(card_removed, 10, n);
    check({card_removed, card_supply_enable, card_present}, 16'h0004);
    step(20);
    check({card_reset_out, card_io_oe, card_clock_out, card_ready}, 16'h0000);
  endtask : t_remove_powered

  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  initial begin
    step(12);
    rst = 1'b0;
    step(2);
    t_reset_values();
    t_cancel_settle();
    t_settle_time();
    t_link_tx();
    t_rx_parity();
    t_remove_powered();
    end_of_test();
  end

  // Cycle ceiling well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      end_of_test();
    end
  end
endmodule : tb_sim_presence_power_seq
